// ---- design/pcs_map.svh ----
// Offsets, field positions, reset values and sizes of the sequencer.
`ifndef PCS_MAP_SVH
`define PCS_MAP_SVH
`define PCS_PC_W 12
`define PCS_PAGE_BITS 9
`define PCS_SEL_W 3
`define PCS_STACK_DEPTH 8
`define PCS_PC_RESET 12'h0fff
// The low counter byte is register index 2; its byte address is four times that.
`define PCS_OFF_PCL 8'h02
`define PCS_ADDR_PCL 8'h08
`define PCS_OFF_PAGE 8'h04
`define PCS_OFF_CTRL 8'h00
`define PCS_OFF_STAT 8'h0c
`define PCS_OFF_FETCH 8'h10
`define PCS_OFF_STK 8'h14
`define PCS_OFF_PROG 8'h18
`endif

// ---- design/pcs_pkg.sv ----
// Types shared by the sequencer modules.
package pcs_pkg;
   typedef enum logic [2:0] {
      PCS_OP_NONE,
      PCS_OP_STEP,
      PCS_OP_JUMP,
      PCS_OP_CALL,
      PCS_OP_RET,
      PCS_OP_PAGE,
      PCS_OP_WRLOW
   } pcs_op_t;
   typedef struct packed {
      logic [11:0] addr;
      logic [11:0] word;
   } pcs_prog_t;
endpackage

// ---- design/pcs_rom.sv ----
// Program store of 4096 twelve-bit words held in flip-flops.
`timescale 1ns/1ps
`include "pcs_map.svh"
module pcs_rom
   import pcs_pkg::*;
#(
   parameter int AW = `PCS_PC_W,
   parameter int DW = 12
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic wr_i,
   input wire pcs_prog_t prog_i,
   input wire logic [AW-1:0] raddr_i,
   output logic [DW-1:0] rdata_o
);
   logic [DW-1:0] mem_ff [2**AW];
   // Loading port for software; fetches read at the counter address.
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < 2**AW; i++) begin
            mem_ff[i] <= '0;
         end
      end else if (wr_i) begin
         mem_ff[prog_i.addr] <= prog_i.word; // [R1]
      end
   end
   assign rdata_o = mem_ff[raddr_i]; // [R1]
endmodule

// ---- design/pcs_stack.sv ----
// Eight-entry return address stack for the sequencer.
`timescale 1ns/1ps
`include "pcs_map.svh"
module pcs_stack
   import pcs_pkg::*;
#(
   parameter int DEPTH = `PCS_STACK_DEPTH,
   parameter int W = `PCS_PC_W
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic push_i,
   input wire logic pop_i,
   input wire logic [W-1:0] din_i,
   output logic [W-1:0] top_o
);
   logic [W-1:0] ent_ff [DEPTH];
   // Shift register stack; entry zero is the top, the oldest falls off.
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < DEPTH; i++) begin
            ent_ff[i] <= '0;
         end
      end else if (push_i) begin
         ent_ff[0] <= din_i; // [R12]
         for (int i = 1; i < DEPTH; i++) begin
            ent_ff[i] <= ent_ff[i-1]; // [R14]
         end
      end else if (pop_i) begin
         for (int i = 0; i < DEPTH - 1; i++) begin
            ent_ff[i] <= ent_ff[i+1]; // [R12]
         end
         ent_ff[DEPTH-1] <= '0; // Bottom refills so an empty pop gives zero.
      end
   end
   assign top_o = ent_ff[0];
endmodule

// ---- design/pcs_top.sv ----
// Program counter, page select and return stack with AXI4-Lite access.
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
`include "pcs_map.svh"
// Summary of operation
// [R1] Program store holds 4096 twelve-bit words fetched at the counter.
// [R2] Counter is twelve bits and holds the next instruction address.
// [R3] Without branches the counter steps by one and wraps to zero.
// [R4] Pages are 512 words; low nine bits span a page.
// [R5] Stepping carries across page boundaries with no stall.
// [R6] Low eight counter bits read and write at location 02h.
// [R7] Jumps and calls take top three bits from page select.
// [R8] Software sets page select before branching to another page.
// [R9] Page instruction loads page select from its operand.
// [R10] Reset loads the counter with all ones.
// [R11] Return stack has eight twelve-bit entries.
// [R12] Calls push return address, returns pop it into the counter.
// [R13] Stack has no data memory read or write path.
// [R14] Pushing onto a full stack drops the oldest entry silently.
module pcs_top
   import pcs_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic op_valid_i,
   input wire pcs_op_t op_i,
   input wire logic [8:0] op_target_i,
   input wire logic [2:0] op_page_i,
   output logic [11:0] pc_o,
   output logic [11:0] instr_o
);
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   //--------------------------------------------------------------
   // Sequencer state
   //--------------------------------------------------------------
   logic [11:0] pc_ff;
   logic [11:0] nxt_pc;
   logic [2:0] page_sel_ff;
   logic [2:0] nxt_page_sel;
   logic [3:0] depth_ff;
   logic push;
   logic pop;
   logic [11:0] stack_top;
   logic [11:0] fetch_word;
   logic sw_wr_low;
   logic sw_wr_page;
   logic sw_op;
   logic sw_prog_wr;
   logic [7:0] wr_low_val;
   logic [31:0] wbuf;
   logic [7:0] waddr_ff;
   logic [31:0] wdata_ff;
   logic [3:0] wstrb_ff;
   logic aw_have_ff;
   logic w_have_ff;
   logic do_write;
   logic ack_ok;
   logic [11:0] instr_ff;
   pcs_prog_t prog_word;
   pcs_op_t cur_op;
   logic cur_valid;

   // Byte merge of a write word under its strobes.
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return r;
   endfunction

   // Software operations take precedence over the core decoder.
   always_comb begin
      cur_valid = op_valid_i;
      cur_op = op_i;
      if (sw_op) begin
         cur_valid = 1'b1;
         cur_op = pcs_op_t'(wbuf[2:0]);
      end
   end

   // Next counter value for each sequencing operation.
   always_comb begin
      nxt_pc = pc_ff;
      push = 1'b0;
      pop = 1'b0;
      if (sw_wr_low) begin
         nxt_pc = {pc_ff[11:8], wr_low_val}; // [R6]
      end else if (cur_valid) begin
         case (cur_op)
            PCS_OP_STEP: begin
               nxt_pc = pc_ff + 12'h001; // [R3] [R5]
            end
            PCS_OP_JUMP: begin
               nxt_pc = {page_sel_ff, op_target_i}; // [R7] [R4]
            end
            PCS_OP_CALL: begin
               nxt_pc = {page_sel_ff, op_target_i}; // [R7]
               push = 1'b1; // [R12]
            end
            PCS_OP_RET: begin
               nxt_pc = stack_top; // [R12]
               pop = 1'b1;
            end
            PCS_OP_WRLOW: begin
               nxt_pc = {pc_ff[11:8], op_target_i[7:0]}; // [R6]
            end
            default: begin
               nxt_pc = pc_ff;
            end
         endcase
      end
   end

   // Page select comes from a page operation or a software write.
   always_comb begin
      nxt_page_sel = page_sel_ff;
      if (sw_wr_page) begin
         nxt_page_sel = wbuf[2:0];
      end else if (cur_valid && cur_op == PCS_OP_PAGE) begin
         nxt_page_sel = op_page_i; // [R9]
      end
   end

   // Program counter register.
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pc_ff <= `PCS_PC_RESET; // [R10]
      end else begin
         pc_ff <= nxt_pc; // [R2]
      end
   end

   // Page select register.
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         page_sel_ff <= 3'h0;
      end else begin
         page_sel_ff <= nxt_page_sel;
      end
   end

   // Occupancy count, saturating at the stack depth.
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         depth_ff <= 4'h0;
      end else if (push && depth_ff != 4'(`PCS_STACK_DEPTH)) begin
         depth_ff <= depth_ff + 4'h1;
      end else if (pop && depth_ff != 4'h0) begin
         depth_ff <= depth_ff - 4'h1;
      end
   end

   // Return stack, reachable only through call and return.
   pcs_stack #(
      .DEPTH(`PCS_STACK_DEPTH),
      .W(`PCS_PC_W)
   ) u_stack (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .push_i(push),
      .pop_i(pop),
      .din_i(pc_ff + 12'h001),
      .top_o(stack_top)
   ); // [R11] [R13]

   assign prog_word.addr = wbuf[27:16];
   assign prog_word.word = wbuf[11:0];

   // Program store.
   pcs_rom #(
      .AW(`PCS_PC_W),
      .DW(12)
   ) u_rom (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .wr_i(sw_prog_wr),
      .prog_i(prog_word),
      .raddr_i(pc_ff),
      .rdata_o(fetch_word)
   );

   // Registered fetch output.
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         instr_ff <= 12'h000;
      end else begin
         instr_ff <= fetch_word; // [R1]
      end
   end
   assign instr_o = instr_ff;
   assign pc_o = pc_ff;

   //--------------------------------------------------------------
   // AXI4-Lite write channel
   //--------------------------------------------------------------
   assign do_write = aw_have_ff && w_have_ff && !s_axi_bvalid;
   assign wbuf = merge(32'h0000_0000, wdata_ff, wstrb_ff);
   assign wr_low_val = wbuf[7:0];
   assign ack_ok = waddr_ff == `PCS_ADDR_PCL ||
                   waddr_ff == `PCS_OFF_PAGE ||
                   waddr_ff == `PCS_OFF_CTRL ||
                   waddr_ff == `PCS_OFF_PROG;
   assign sw_wr_low = do_write && waddr_ff == `PCS_ADDR_PCL &&
                      wstrb_ff[0];
   assign sw_wr_page = do_write && waddr_ff == `PCS_OFF_PAGE &&
                       wstrb_ff[0];
   assign sw_op = do_write && waddr_ff == `PCS_OFF_CTRL && wstrb_ff[0];
   assign sw_prog_wr = do_write && waddr_ff == `PCS_OFF_PROG &&
                       wstrb_ff == 4'hf;

   // Address and data are captured independently, in either order.
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         aw_have_ff <= 1'b0;
         waddr_ff <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_have_ff <= 1'b1;
         waddr_ff <= {s_axi_awaddr[7:2], 2'b00};
      end else if (do_write) begin
         aw_have_ff <= 1'b0;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         w_have_ff <= 1'b0;
         wdata_ff <= 32'h0000_0000;
         wstrb_ff <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_have_ff <= 1'b1;
         wdata_ff <= s_axi_wdata;
         wstrb_ff <= s_axi_wstrb;
      end else if (do_write) begin
         w_have_ff <= 1'b0;
      end
   end

   // Ready flags drop once an item is held and stay low until the
   // response has been taken.
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_awready <= !aw_have_ff && !s_axi_bvalid &&
                          !(s_axi_awvalid && s_axi_awready);
         s_axi_wready <= !w_have_ff && !s_axi_bvalid &&
                         !(s_axi_wvalid && s_axi_wready);
      end
   end

   // Write response.
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= ack_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   //--------------------------------------------------------------
   // AXI4-Lite read channel
   //--------------------------------------------------------------
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_axi_arready <= 1'b0;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid &&
                          s_axi_arready);
      end
   end

   // Read data; the stack contents themselves are never exposed.
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= RESP_OKAY;
         case ({s_axi_araddr[7:2], 2'b00})
            `PCS_ADDR_PCL: s_axi_rdata <= {24'h00_0000, pc_ff[7:0]}; // [R6]
            `PCS_OFF_PAGE: s_axi_rdata <= {29'h0, page_sel_ff};
            `PCS_OFF_CTRL: s_axi_rdata <= 32'h0000_0000;
            `PCS_OFF_STAT: s_axi_rdata <= {20'h0_0000, pc_ff};
            `PCS_OFF_FETCH: s_axi_rdata <= {20'h0_0000, fetch_word};
            `PCS_OFF_STK: s_axi_rdata <= {28'h000_0000, depth_ff};
            `PCS_OFF_PROG: s_axi_rdata <= 32'h0000_0000;
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule

// ---- tb/pcs_core_model.sv ----
// Model of the core decode that offers one operation per cycle.
`timescale 1ns/1ps
module pcs_core_model
   import pcs_pkg::*;
(
   input wire logic mclk_i,
   output logic op_valid_o,
   output pcs_op_t op_o,
   output logic [8:0] op_target_o,
   output logic [2:0] op_page_o
);
   // Nothing is offered before the bench asks.
   initial begin
      op_valid_o = 1'b0;
      op_o = PCS_OP_NONE;
      op_target_o = 9'h000;
      op_page_o = 3'h0;
   end
   // Offers an operation after an edge; the next edge takes it.
   task automatic issue(input pcs_op_t op, input logic [8:0] t,
      input logic [2:0] p);
      @(posedge mclk_i);
      op_valid_o <= 1'b1;
      op_o <= op;
      op_target_o <= t;
      op_page_o <= p;
   endtask
   // Withdraws and scrambles operands so stale values never match.
   task automatic idle();
      @(posedge mclk_i);
      op_valid_o <= 1'b0;
      op_target_o <= ~op_target_o;
      op_page_o <= ~op_page_o;
   endtask
endmodule

// ---- tb/pcs_sva.sv ----
// Checker of counter and bus timing at the sequencer ports.
`timescale 1ns/1ps
module pcs_sva
   import pcs_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic op_valid_i,
   input wire pcs_op_t op_i,
   input wire logic [8:0] op_target_i,
   input wire logic [11:0] pc_o
);
   // Idle bus: no software write can override the core this cycle.
   logic idle;
   logic q;
   assign idle = s_axi_awready & s_axi_wready;
   assign q = idle & op_valid_i;
   default clocking @(posedge mclk_i);
   endclocking
   default disable iff (!rst_n_i);
   chk_reset_top: assert property (disable iff (1'b0)
      !rst_n_i |-> pc_o == 12'h0fff) else $error("Bad reset pc.");
   chk_step_one: assert property (q && op_i == PCS_OP_STEP
      |=> pc_o == $past(pc_o) + 12'h001) else $error("Bad step.");
   chk_hold_pc: assert property (idle && !op_valid_i
      |=> $stable(pc_o)) else $error("Counter moved.");
   chk_jump_low: assert property (q && op_i == PCS_OP_JUMP
      |=> pc_o[8:0] == $past(op_target_i)) else $error("Bad jump.");
   chk_call_ret: assert property (q && op_i == PCS_OP_RET
      && $past(q && op_i == PCS_OP_CALL)
      |=> pc_o == $past(pc_o, 2) + 12'h001) else $error("Bad return.");
   chk_low_write: assert property (q && op_i == PCS_OP_WRLOW
      |=> pc_o == {$past(pc_o[11:8]), $past(op_target_i[7:0])})
      else $error("Bad low write.");
   chk_read_lat: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid) else $error("Late read data.");
   chk_write_busy: assert property (s_axi_bvalid
      |-> !(s_axi_awready || s_axi_wready)) else $error("Busy taken.");
endmodule
bind pcs_top pcs_sva u_pcs_sva (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
   .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
   .op_valid_i(op_valid_i), .op_i(op_i), .op_target_i(op_target_i),
   .pc_o(pc_o));

// ---- tb/testbench.sv ----
// Self-checking bench for counter, page select, store and stack.
`timescale 1ns/1ps
module testbench;
   import pcs_pkg::*;
   typedef struct packed {
      pcs_op_t op;
      logic [8:0] t;
      logic [2:0] p;
      logic [11:0] pc;
   } pcs_row_t;
   logic mclk_i = 1'b0;
   logic rst_n_i = 1'b1;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_awready;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_wready;
   logic [1:0] s_axi_bresp;
   logic s_axi_bvalid;
   logic s_axi_bready = 1'b0;
   logic [7:0] s_axi_araddr = 8'h00;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0] s_axi_rresp;
   logic s_axi_rvalid;
   logic s_axi_rready = 1'b0;
   logic op_valid_i;
   pcs_op_t op_i;
   logic [8:0] op_target_i;
   logic [2:0] op_page_i;
   logic [11:0] pc_o;
   logic [11:0] instr_o;
   logic [31:0] rd;
   logic [1:0] rs;
   int errors = 0;
   int n_compared = 0;
   int cyc = 0;
   // Ops in order from reset, each with the counter it must give.
   pcs_row_t rows [11] = '{
      '{PCS_OP_STEP, 9'h000, 3'h0, 12'h000},
      '{PCS_OP_WRLOW, 9'h0ff, 3'h0, 12'h0ff},
      '{PCS_OP_STEP, 9'h000, 3'h0, 12'h100},
      '{PCS_OP_JUMP, 9'h1ff, 3'h0, 12'h1ff},
      '{PCS_OP_STEP, 9'h000, 3'h0, 12'h200},
      '{PCS_OP_PAGE, 9'h000, 3'h3, 12'h200},
      '{PCS_OP_JUMP, 9'h005, 3'h0, 12'h605},
      '{PCS_OP_CALL, 9'h010, 3'h0, 12'h610},
      '{PCS_OP_CALL, 9'h020, 3'h0, 12'h620},
      '{PCS_OP_RET, 9'h000, 3'h0, 12'h611},
      '{PCS_OP_RET, 9'h000, 3'h0, 12'h606}};
   pcs_top u_pcs_top (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .op_valid_i(op_valid_i), .op_i(op_i),
      .op_target_i(op_target_i), .op_page_i(op_page_i), .pc_o(pc_o),
      .instr_o(instr_o));
   pcs_core_model u_pcs_core_model (.mclk_i(mclk_i),
      .op_valid_o(op_valid_i), .op_o(op_i), .op_target_o(op_target_i),
      .op_page_o(op_page_i));
   // Clock of 8 ns period.
   always #4 mclk_i = ~mclk_i;
   // Ends a hung run as a mismatch.
   always @(posedge mclk_i) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         errors = errors + 1;
         summarize();
      end
   end
   task automatic summarize();
      $display("Compared %0d, mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      n_compared = n_compared + 1;
      if (g !== e) begin
         errors = errors + 1;
         $display("Error at %0t: got %h, expected %h", $time, g, e);
      end
   endtask
   // Bus write: address and data offered together, each held until taken.
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s);
      @(posedge mclk_i);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge mclk_i);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   // Bus read: address held until taken, data taken with rvalid.
   task automatic rdr(input logic [7:0] a);
      @(posedge mclk_i);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge mclk_i);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   // Main sequence.
   initial begin
      rst_n_i <= 1'b0;
      repeat (6) @(posedge mclk_i);
      cmp(pc_o, 12'h0fff);
      rst_n_i <= 1'b1;
      foreach (rows[i]) begin
         u_pcs_core_model.issue(rows[i].op, rows[i].t, rows[i].p);
         u_pcs_core_model.idle();
         #1;
         cmp(pc_o, rows[i].pc);
      end
      $display("Table of core ops done.");
      wr(8'h08, 32'h0000_0034, 4'h1);
      cmp(rs, 2'b00);
      rdr(8'h0c);
      cmp(rd, 32'h0000_0634);
      rdr(8'h08);
      cmp(rd[7:0], 8'h34);
      rdr(8'h40);
      cmp(rs, 2'b10);
      wr(8'h40, 32'h0000_0001, 4'hf);
      cmp(rs, 2'b10);
      wr(8'h04, 32'h0000_0005, 4'h1);
      rdr(8'h04);
      cmp(rd, 32'h0000_0005);
      wr(8'h00, 32'h0000_0001, 4'h1);
      rdr(8'h0c);
      cmp(rd, 32'h0000_0635);
      $display("Register access done.");
      wr(8'h18, 32'h0123_0abc, 4'hf);
      u_pcs_core_model.issue(PCS_OP_PAGE, 9'h000, 3'h0);
      u_pcs_core_model.issue(PCS_OP_JUMP, 9'h123, 3'h0);
      u_pcs_core_model.idle();
      @(posedge mclk_i);
      #1;
      cmp(instr_o, 12'habc);
      rdr(8'h10);
      cmp(rd, 32'h0000_0abc);
      $display("Program store done.");
      for (int k = 1; k <= 9; k++) begin
         u_pcs_core_model.issue(PCS_OP_CALL, 9'(k * 16), 3'h0);
      end
      for (int k = 8; k >= 0; k--) begin
         u_pcs_core_model.issue(PCS_OP_RET, 9'h000, 3'h0);
         u_pcs_core_model.idle();
         #1;
         cmp(pc_o, 32'((k == 0) ? 0 : k * 16 + 1));
         if (k == 8) begin
            rdr(8'h14);
            cmp(rd, 32'h0000_0007);
         end
      end
      $display("Stack overflow done.");
      @(posedge mclk_i);
      rst_n_i <= 1'b0;
      repeat (2) @(posedge mclk_i);
      #1;
      cmp(pc_o, 12'h0fff);
      @(posedge mclk_i);
      rst_n_i <= 1'b1;
      rdr(8'h14);
      cmp(rd, 32'h0000_0000);
      $display("Second reset done.");
      summarize();
   end
endmodule
